// *** bpt_params.svh ***
// Named offsets, field positions and reset values of the timed byte port.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef BPT_PARAMS_SVH
`define BPT_PARAMS_SVH

// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define BPT_IDX_DATA      6'h38
`define BPT_IDX_CTRL      6'h3C
`define BPT_IDX_FUNC      6'h3D
`define BPT_IDX_DRIVE     6'h3E
`define BPT_IDX_DIR       6'h3F
`define BPT_IDX_GROUP     2'h3
`define BPT_IDX_LSB       2
`define BPT_IDX_MSB       7

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define BPT_PINS          8
`define BPT_NIB_W         4
`define BPT_SEL_LOWER_LSB 0
`define BPT_SEL_UPPER_LSB 4
`define BPT_DIR_RESET     8'h00
`define BPT_ZERO_BYTE     8'h00
`define BPT_ZERO_WORD     32'h00000000
`define BPT_RESP_OKAY     2'h0
`define BPT_RESP_SLVERR   2'h2

`endif

// *** bpt_pkg.sv ***
// Types shared by the timed byte port design.
// Assumes the constants header is available on the include path.
package bpt_pkg;

    // ****************************************************************
    // Transfer timing source of one output nibble.
    // ****************************************************************
    typedef enum logic [1:0]
    {
        BPT_CLK_HALF,
        BPT_CLK_A1,
        BPT_CLK_B1,
        BPT_CLK_B2
    } bpt_clksel_t;

    // ****************************************************************
    // On-chip timer ticks, one-cycle pulses on clk.
    // ****************************************************************
    typedef struct packed
    {
        logic a1;
        logic b1;
        logic b2;
    } bpt_tick_t;

    // ****************************************************************
    // Alternate function signals from on-chip peripherals.
    // ****************************************************************
    typedef struct packed
    {
        logic [3:0] pwm;
        logic       sclk_c;
        logic       sclk_d;
        logic       sclk_c_int;
        logic       sclk_d_int;
    } bpt_alt_t;

endpackage : bpt_pkg

// *** bpt_sync.sv ***
// Two-stage synchroniser for the port pin input levels.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "bpt_params.svh"

module bpt_sync
    import bpt_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic [`BPT_PINS-1:0] pin_async,
    output var  logic [`BPT_PINS-1:0] pin_sync
);

    logic [`BPT_PINS-1:0] pin_meta;

    // First stage feeds only the second stage.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta <= `BPT_ZERO_BYTE;
            pin_sync <= `BPT_ZERO_BYTE;
        end
        else
        begin
            pin_meta <= pin_async;
            pin_sync <= pin_meta;
        end
    end

endmodule : bpt_sync

`default_nettype wire

// *** bpt_port.sv ***
// Eight-bit port with preload, timed nibble transfer and alternate functions.
// Assumes an AXI4-Lite master on clk and timer ticks synchronous to clk.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bpt_params.svh"

module bpt_port
    import bpt_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic [7:0]           s_awaddr,
    input  wire logic                 s_awvalid,
    output var  logic                 s_awready,
    input  wire logic [31:0]          s_wdata,
    input  wire logic [3:0]           s_wstrb,
    input  wire logic                 s_wvalid,
    output var  logic                 s_wready,
    output var  logic [1:0]           s_bresp,
    output var  logic                 s_bvalid,
    input  wire logic                 s_bready,
    input  wire logic [7:0]           s_araddr,
    input  wire logic                 s_arvalid,
    output var  logic                 s_arready,
    output var  logic [31:0]          s_rdata,
    output var  logic [1:0]           s_rresp,
    output var  logic                 s_rvalid,
    input  wire logic                 s_rready,
    input  wire bpt_tick_t            tick,
    input  wire bpt_alt_t             alt,
    input  wire logic                 other_port_output_mode,
    input  wire logic [`BPT_PINS-1:0] pin_in,
    output var  logic [`BPT_PINS-1:0] pin_out,
    output var  logic [`BPT_PINS-1:0] pin_oe,
    output var  logic [`BPT_PINS-1:0] quad_in,
    output var  logic [`BPT_PINS-1:0] other_port_data,
    output var  logic                 other_port_oe
);

    // ****************************************************************
    // Storage.
    // ****************************************************************
    logic [`BPT_PINS-1:0] pin_sync;
    logic [`BPT_PINS-1:0] pin_data_preload;
    wire  [`BPT_PINS-1:0] final_out;
    logic [`BPT_PINS-1:0] alternate_function_enable;
    logic [`BPT_PINS-1:0] open_drain_select;
    logic [`BPT_PINS-1:0] pin_direction;
    bpt_clksel_t          sel_upper;
    bpt_clksel_t          sel_lower;
    logic                 half_phase;
    logic [5:0]           wr_idx;
    logic [7:0]           wr_byte;
    logic                 wr_lane;

    bpt_sync u_sync
    (
        .clk       (clk),
        .reset_n   (reset_n),
        .pin_async (pin_in),
        .pin_sync  (pin_sync)
    );

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    wire       do_write   = !s_awready && !s_wready && !s_bvalid;
    wire       wr_group   = (wr_idx[5:4] == `BPT_IDX_GROUP);
    wire       wr_en      = do_write && wr_lane;
    wire       wr_data    = wr_en && (wr_idx == `BPT_IDX_DATA);
    wire       wr_ctrl    = wr_en && (wr_idx == `BPT_IDX_CTRL);
    wire       wr_func    = wr_en && (wr_idx == `BPT_IDX_FUNC);
    wire       wr_drive   = wr_en && (wr_idx == `BPT_IDX_DRIVE);
    wire       wr_dir     = wr_en && (wr_idx == `BPT_IDX_DIR);
    wire       wr_other   = wr_en && wr_group;
    wire [5:0] rd_idx     = s_araddr[`BPT_IDX_MSB:`BPT_IDX_LSB];
    wire       rd_take    = s_arvalid && s_arready;
    wire       rd_group   = (rd_idx[5:4] == `BPT_IDX_GROUP);
    // Write-only registers read as zero so software cannot mistake them for state.
    wire [31:0] rd_word   = (rd_idx == `BPT_IDX_DATA) ? {24'h000000, pin_sync} : `BPT_ZERO_WORD;

    // ****************************************************************
    // AXI4-Lite write channel; address and data may come in either order.
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= `BPT_RESP_OKAY;
        end
        else if (s_bvalid && s_bready)
        begin
            s_bvalid  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
        end
        else
        begin
            if (s_awvalid && s_awready)
                s_awready <= 1'b0;
            if (s_wvalid && s_wready)
                s_wready <= 1'b0;
            if (do_write)
            begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_group ? `BPT_RESP_OKAY : `BPT_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (s_awvalid && s_awready)
            wr_idx <= s_awaddr[`BPT_IDX_MSB:`BPT_IDX_LSB];
        if (s_wvalid && s_wready)
        begin
            wr_byte <= s_wdata[7:0];
            wr_lane <= s_wstrb[0];
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel.
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= `BPT_ZERO_WORD;
            s_rresp   <= `BPT_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_word;
            s_rresp   <= rd_group ? `BPT_RESP_OKAY : `BPT_RESP_SLVERR;
        end
        else if (s_rvalid && s_rready)
        begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // Control registers.
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_direction <= `BPT_DIR_RESET;
            sel_upper     <= BPT_CLK_HALF;
            sel_lower     <= BPT_CLK_HALF;
            half_phase    <= 1'b0;
        end
        else
        begin
            half_phase <= !half_phase;
            if (wr_dir)
                pin_direction <= wr_byte;
            if (wr_ctrl)
            begin
                sel_upper <= bpt_clksel_t'(wr_byte[`BPT_SEL_UPPER_LSB +: 2]);
                sel_lower <= bpt_clksel_t'(wr_byte[`BPT_SEL_LOWER_LSB +: 2]);
            end
        end
    end

    // No reset here: these hold whatever they powered up with until written.
    always_ff @(posedge clk)
    begin
        if (wr_data)
            pin_data_preload <= wr_byte;
        if (wr_func)
            alternate_function_enable <= wr_byte;
        if (wr_drive)
            open_drain_select <= wr_byte;
    end

    // ****************************************************************
    // Other port output register, shared with slave port output zero.
    // ****************************************************************
    // The decode covers the whole block, so every write here lands there too.
    always_ff @(posedge clk)
    begin
        if (wr_other)
            other_port_data <= wr_byte;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            other_port_oe <= 1'b0;
        else
            other_port_oe <= other_port_output_mode;
    end

    // ****************************************************************
    // Timed nibble transfer.
    // ****************************************************************
    genvar n;
    generate
        for (n = 0; n < 2; n++)
        begin : g_nib
            wire bpt_clksel_t sel = (n == 1) ? sel_upper : sel_lower;
            wire strobe = (sel == BPT_CLK_HALF) ? half_phase :
                          (sel == BPT_CLK_A1)   ? tick.a1    :
                          (sel == BPT_CLK_B1)   ? tick.b1    : tick.b2;
            logic [`BPT_NIB_W-1:0] nib_out;
            // Each nibble keeps its own register so that no two processes write one variable.
            always_ff @(posedge clk)
            begin
                if (strobe)
                    nib_out <= pin_data_preload[n*`BPT_NIB_W +: `BPT_NIB_W];
            end
            assign final_out[n*`BPT_NIB_W +: `BPT_NIB_W] = nib_out;
        end
    endgenerate

    // ****************************************************************
    // Pin drive.
    // ****************************************************************
    wire [7:0] alt_force = {6'h00, alt.sclk_c_int, alt.sclk_d_int};
    wire [7:0] alt_on    = {alternate_function_enable[7:4], 2'h0,
                            alternate_function_enable[1:0]} | alt_force;
    wire [7:0] alt_val   = {alt.pwm, 2'h0, alt.sclk_c, alt.sclk_d};
    wire  [7:0] next_pin_out;
    wire  [7:0] next_pin_oe;

    genvar i;
    generate
        for (i = 0; i < `BPT_PINS; i++)
        begin : g_pin
            wire value    = alt_on[i] ? alt_val[i] : final_out[i];
            wire drive_on = pin_direction[i] | alt_force[i];
            // Open-drain only ever pulls low; a high bit releases the pin.
            assign next_pin_out[i] = drive_on & ~open_drain_select[i] & value;
            assign next_pin_oe[i]  = drive_on & (~open_drain_select[i] | ~value);
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out <= `BPT_ZERO_BYTE;
            pin_oe  <= `BPT_ZERO_BYTE;
            quad_in <= `BPT_ZERO_BYTE;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
            quad_in <= pin_sync;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // The preload holds no defined value until software writes it, so the half-clock transfer check waits for that.
    logic preload_seen;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            preload_seen <= 1'b0;
        else if (wr_data)
            preload_seen <= 1'b1;
    end

    sequence s_write_dir;
        wr_dir ##1 1'b1;
    endsequence

    a_dir_write_lands: assert property (s_write_dir |-> pin_direction == $past(wr_byte))
        else $error("direction register missed a write");
    a_read_pin_level: assert property (rd_take && rd_idx == `BPT_IDX_DATA
        |=> s_rvalid && s_rdata[7:0] == $past(pin_sync))
        else $error("data read did not return pin levels");
    a_half_transfer: assert property (preload_seen && sel_lower == BPT_CLK_HALF && half_phase
        |=> final_out[3:0] == $past(pin_data_preload[3:0]))
        else $error("lower nibble not moved on half clock");
    a_timer_hold: assert property (sel_upper == BPT_CLK_A1 && !tick.a1
        |=> $stable(final_out[7:4]))
        else $error("upper nibble moved without timer tick");
    a_wo_read_zero: assert property (rd_take && rd_idx != `BPT_IDX_DATA
        |=> s_rdata == `BPT_ZERO_WORD)
        else $error("non-data register read back nonzero");
    a_od_never_high: assert property (##1 (pin_out & $past(open_drain_select)) == `BPT_ZERO_BYTE)
        else $error("open-drain pin driven high");
    a_pwm_route: assert property (alternate_function_enable[7] && pin_direction[7] && !open_drain_select[7]
        |=> pin_oe[7] && pin_out[7] == $past(alt.pwm[3]))
        else $error("pwm 3 not on pin 7");
    a_sclk_force: assert property (alt.sclk_c_int && !open_drain_select[1]
        |=> pin_oe[1] && pin_out[1] == $past(alt.sclk_c))
        else $error("internal serial clock not forced out");
    a_quad_follow: assert property (##1 quad_in == $past(pin_sync))
        else $error("decoder inputs do not follow pins");
    a_other_spurious: assert property (wr_other |=> other_port_data == $past(wr_byte))
        else $error("other port register missed spurious write");
    a_other_hidden: assert property (!other_port_output_mode |=> !other_port_oe)
        else $error("other port register exposed while unused");
    a_pin_inactive: assert property (pin_direction == `BPT_ZERO_BYTE && !alt.sclk_c_int && !alt.sclk_d_int
        |=> pin_oe == `BPT_ZERO_BYTE)
        else $error("input pin is being driven");
    a_write_answer: assert property (do_write |=> s_bvalid)
        else $error("write response missing");

endmodule : bpt_port

`default_nettype wire

// *** bpt_far_side.sv ***
// Far-side model of the timed byte port: outside pin drivers and timer outputs.
// Assumes the bench asks for timer strobes through fire and sets outside levels.
`timescale 1ns/1ps
`default_nettype none

module bpt_far_side
    import bpt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] fire,
    input  wire logic [7:0] ext_level,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    output var  bpt_tick_t  tick,
    output var  logic [7:0] pin_level
);
    // ****************************************************************
    // Pin resolution and timer strobes.
    // ****************************************************************
    // A released pin shows the outside level, which stands for a pull-up where one is fitted.
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);

    // Timer outputs copy fire one cycle later, so a one-cycle request gives a one-cycle strobe to every nibble that selects it.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            tick <= '0;
        else
            tick <= bpt_tick_t'(fire);
    end
endmodule : bpt_far_side

`default_nettype wire

// *** byte_port_timed_outputs_tb.sv ***
// Self-checking bench of the timed byte port, driven over AXI4-Lite.
// Assumes bpt_port and bpt_far_side; ticks come from the far-side model.
`timescale 1ns/1ps
`default_nettype none
`include "bpt_params.svh"

module byte_port_timed_outputs_tb
    import bpt_pkg::*;
;
    localparam logic [7:0] A_DATA  = {`BPT_IDX_DATA, 2'b00};
    localparam logic [7:0] A_CTRL  = {`BPT_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_FUNC  = {`BPT_IDX_FUNC, 2'b00};
    localparam logic [7:0] A_DRIVE = {`BPT_IDX_DRIVE, 2'b00};
    localparam logic [7:0] A_DIR   = {`BPT_IDX_DIR, 2'b00};
    logic        clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, opm, opoe;
    logic [7:0]  awaddr, araddr, pin_in, pin_out, pin_oe, quad_in, opd, ext;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp;
    logic [2:0]  fire;
    bpt_tick_t   tick;
    bpt_alt_t    alt;
    int          errors, n_compared;

    bpt_port i_bpt_port (.clk(clk), .reset_n(reset_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .tick(tick), .alt(alt), .other_port_output_mode(opm), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .quad_in(quad_in), .other_port_data(opd), .other_port_oe(opoe));
    bpt_far_side i_bpt_far_side (.clk(clk), .reset_n(reset_n), .fire(fire), .ext_level(ext),
        .pin_out(pin_out), .pin_oe(pin_oe), .tick(tick), .pin_level(pin_in));

    always #12.5 clk = ~clk;

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Bready stays high once raised; lowering it would collide with the next write's raise.
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!(bvalid && bready));
        chk(bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!(rvalid && rready));
        d = rdata;
        chk(rresp, er);
    endtask : rd
    task automatic pulse(input logic [2:0] f);
        fire <= f;
        @(posedge clk);
        fire <= 3'h0;
    endtask : pulse

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset;
        cyc(4);
        chk(pin_oe, 8'h00);
        rd(A_DATA, `BPT_RESP_OKAY);
        chk(d, 32'h0000005A);
        chk(quad_in, 8'h5A);
    endtask : t_reset
    // Control is left at its reset value here, so the half-clock transfer must already work.
    task automatic t_half;
        wr(A_FUNC, 8'h00, `BPT_RESP_OKAY);
        wr(A_DRIVE, 8'h00, `BPT_RESP_OKAY);
        // Preload goes first so that the pins never drive the undefined output register.
        wr(A_DATA, 8'hA5, `BPT_RESP_OKAY);
        wr(A_DIR, 8'hFF, `BPT_RESP_OKAY);
        cyc(4);
        chk(pin_out, 8'hA5);
        chk(pin_oe, 8'hFF);
        rd(A_DATA, `BPT_RESP_OKAY);
        chk(d, 32'h000000A5);
    endtask : t_half
    task automatic t_select;
        logic [1:0] c;
        logic [2:0] b;
        logic [7:0] e;
        e = 8'hA5;
        for (int s = 1; s < 4; s++)
        begin
            c = s[1:0];
            b = 3'h4 >> (s - 1);
            wr(A_CTRL, {2'b00, c, 2'b00, c}, `BPT_RESP_OKAY);
            wr(A_DATA, ~e, `BPT_RESP_OKAY);
            cyc(4);
            chk(pin_out, e);
            pulse(3'h7 ^ b);
            cyc(4);
            chk(pin_out, e);
            pulse(b);
            cyc(4);
            e = ~e;
            chk(pin_out, e);
        end
        wr(A_CTRL, 8'h10, `BPT_RESP_OKAY);
        wr(A_DATA, 8'h3C, `BPT_RESP_OKAY);
        cyc(4);
        chk(pin_out, {e[7:4], 4'hC});
        pulse(3'h4);
        cyc(4);
        chk(pin_out, 8'h3C);
    endtask : t_select
    task automatic t_drain;
        ext <= 8'hFF;
        wr(A_CTRL, 8'h00, `BPT_RESP_OKAY);
        wr(A_DATA, 8'h0F, `BPT_RESP_OKAY);
        wr(A_DRIVE, 8'hFF, `BPT_RESP_OKAY);
        cyc(4);
        chk(pin_out, 8'h00);
        chk(pin_oe, 8'hF0);
        chk(quad_in, 8'h0F);
    endtask : t_drain
    task automatic t_alt;
        // Every routed pin carries the opposite of its output register bit, so each route is seen.
        alt <= 8'hA4;
        wr(A_DRIVE, 8'h00, `BPT_RESP_OKAY);
        wr(A_DATA, 8'h5E, `BPT_RESP_OKAY);
        wr(A_FUNC, 8'hF3, `BPT_RESP_OKAY);
        cyc(4);
        chk(pin_out, 8'hAD);
        wr(A_DIR, 8'h00, `BPT_RESP_OKAY);
        cyc(2);
        chk(pin_oe, 8'h00);
        alt <= 8'hAF;
        cyc(3);
        chk(pin_oe, 8'h03);
        chk(pin_out & 8'h03, 8'h03);
        alt <= 8'h00;
    endtask : t_alt
    task automatic t_flaw;
        wr(8'hC0, 8'h3C, `BPT_RESP_OKAY);
        chk(opd, 8'h3C);
        wr(8'hBC, 8'h55, `BPT_RESP_SLVERR);
        chk(opd, 8'h3C);
        wr(A_CTRL, 8'hCC, `BPT_RESP_OKAY);
        chk(opd, 8'hCC);
        wr(A_FUNC, 8'h00, `BPT_RESP_OKAY);
        wr(A_DIR, 8'hFF, `BPT_RESP_OKAY);
        wr(A_DATA, 8'h96, `BPT_RESP_OKAY);
        cyc(4);
        chk(pin_out, 8'h96);
        chk(opd, 8'h96);
        rd(A_CTRL, `BPT_RESP_OKAY);
        chk(d, 32'h00000000);
        rd(8'hC0, `BPT_RESP_OKAY);
        chk(d, 32'h00000000);
        rd(8'h80, `BPT_RESP_SLVERR);
        chk(d, 32'h00000000);
        opm <= 1'b1;
        cyc(2);
        chk(opoe, 1'b1);
        opm <= 1'b0;
        cyc(2);
        chk(opoe, 1'b0);
    endtask : t_flaw

    task automatic test_done;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        test_done();
    end

    initial
    begin
        {clk, reset_n, awvalid, wvalid, bready, arvalid, rready, opm} = '0;
        {awaddr, araddr, wdata, fire, alt} = '0;
        ext = 8'h5A;
        errors = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_half();
        t_select();
        t_drain();
        t_alt();
        t_flaw();
        test_done();
    end
endmodule : byte_port_timed_outputs_tb

`default_nettype wire
